// ---- include/can_mode_map.svh ----
// Register offsets, field positions, reset values and the write mask of the CAN mode control block.
`ifndef CAN_MODE_MAP_SVH
`define CAN_MODE_MAP_SVH

`define CAN_MODULE_CONTROL_ADDR 12'h000
`define CAN_ENGINE_STATUS_ADDR 12'h004
`define ABORT_ALL_BIT 27
`define MODE_REQUEST_LSB 24
`define MODE_STATUS_LSB 21
`define CAPTURE_ENABLE_BIT 20
`define MODULE_ENABLE_BIT 15
`define STOP_IN_IDLE_BIT 13
`define MODULE_BUSY_BIT 11
`define COMPARE_COUNT_LSB 0
`define MODE_RESET_VALUE 3'h4
`define CONTROL_WRITE_MASK 32'h0F10A01F

`endif

// ---- include/can_mode_pkg.sv ----
// Types shared by the CAN mode control block.
package can_mode_pkg;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b000,
      MODE_DISABLE = 3'b001,
      MODE_LOOPBACK = 3'b010,
      MODE_LISTEN_ONLY = 3'b011,
      MODE_CONFIG = 3'b100,
      MODE_LISTEN_ALL = 3'b111
   } mode_type;

   typedef struct packed {
      logic abort_all_transmit;
      logic [2:0] mode_request;
      logic timestamp_capture_enable;
      logic module_enable;
      logic stop_in_idle;
      logic [4:0] payload_compare_count;
   } control_type;

   typedef struct packed {
      logic rx_valid;
      logic [15:0] rx_timestamp;
   } capture_type;

endpackage

// ---- hdl/timestamp_timer.sv ----
// Free-running receive time-stamp timer that halts when capture is off.
`timescale 1ns/1ps
module timestamp_timer #(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic tick,
   output logic [WIDTH-1:0] count
);

   initial begin
      if (WIDTH < 2 || WIDTH > 32) begin
         $error("timestamp_timer width out of range");
      end
   end

   // Holding the count with capture off saves toggling power.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count <= '0;
      end else if (run && tick) begin
         count <= count + 1'b1;
      end
   end

endmodule // timestamp_timer

// ---- hdl/can_mode_control.sv ----
// CAN module control word with mode sequencing, abort-all and time-stamp capture.
//
// Contract
// - Setting abort-all signals every transmit buffer to abandon its pending frame.
// - Abort-all clears itself once all pending transmissions have been aborted.
// - Mode request codes: 000 normal, 001 disable, 010 loopback, 011 listen, 100 config, 111 all.
// - Read-only bits 23 to 21 report the current mode, same encoding.
// - With capture set, each valid received frame stores the timer value.
// - With capture clear, no capture is made and the timer halts.
// - Enable bit 15 turns the controller on when 1 and off when 0.
// - Busy stays asserted after disable until the transaction in progress ends.
// - Unimplemented bits, including 31-28, 19-16 and 14, read as 0.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "can_mode_map.svh"
module can_mode_control
   import can_mode_pkg::mode_type;
   import can_mode_pkg::control_type;
   import can_mode_pkg::capture_type;
#(
   parameter int TIMER_WIDTH = 16,
   parameter int TX_BUFFERS = 32
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bus_active,
   input wire logic [TX_BUFFERS-1:0] tx_pending,
   output logic [TX_BUFFERS-1:0] tx_abort,
   input wire logic timer_tick,
   input wire capture_type rx_event,
   output capture_type rx_stamp,
   output can_mode_pkg::mode_type mode_current,
   output logic module_on,
   output logic stop_in_idle,
   output logic [4:0] payload_compare_count
);
   import can_mode_pkg::*;

   initial begin
      if (TX_BUFFERS < 1 || TX_BUFFERS > 32) begin
         $error("can_mode_control supports 1 to 32 transmit buffers");
      end
      if (TIMER_WIDTH != 16) begin
         $error("can_mode_control capture carrier is 16 bits wide");
      end
   end

   // ****************************************
   // Register bus
   // ****************************************
   control_type ctrl;
   logic busy;
   logic [TIMER_WIDTH-1:0] timer_count;
   logic wr_en;
   logic rd_ctrl;
   logic rd_stat;
   logic abort_done;
   logic [31:0] next_prdata;

   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite && (paddr == `CAN_MODULE_CONTROL_ADDR);
   assign rd_ctrl = paddr == `CAN_MODULE_CONTROL_ADDR;
   assign rd_stat = paddr == `CAN_ENGINE_STATUS_ADDR;
   assign pslverr = psel && penable && !(rd_ctrl || (rd_stat && !pwrite));

   always_comb begin
      next_prdata = 32'h0000_0000;
      if (rd_ctrl) begin
         next_prdata[`ABORT_ALL_BIT] = ctrl.abort_all_transmit;
         next_prdata[`MODE_REQUEST_LSB +: 3] = ctrl.mode_request;
         next_prdata[`MODE_STATUS_LSB +: 3] = mode_current;
         next_prdata[`CAPTURE_ENABLE_BIT] = ctrl.timestamp_capture_enable;
         next_prdata[`MODULE_ENABLE_BIT] = ctrl.module_enable;
         next_prdata[`STOP_IN_IDLE_BIT] = ctrl.stop_in_idle;
         next_prdata[`MODULE_BUSY_BIT] = busy;
         next_prdata[`COMPARE_COUNT_LSB +: 5] = ctrl.payload_compare_count;
      end else if (rd_stat) begin
         next_prdata[TX_BUFFERS-1:0] = tx_pending;
      end
   end

   // Read data is registered in the setup cycle so it is stable in the access phase.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // ****************************************
   // Control word
   // ****************************************
   assign abort_done = ctrl.abort_all_transmit && (tx_pending == '0);

   // One process owns the whole control word so no field has two drivers.
   // The abort bit is set-only from software; a write of one wins over the self-clear.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl.abort_all_transmit <= 1'b0;
         ctrl.mode_request <= `MODE_RESET_VALUE;
         ctrl.timestamp_capture_enable <= 1'b0;
         ctrl.module_enable <= 1'b0;
         ctrl.stop_in_idle <= 1'b0;
         ctrl.payload_compare_count <= 5'h00;
      end else begin
         if (wr_en) begin
            // Reserved request codes are kept out of the sequencer below.
            ctrl.mode_request <= pwdata[`MODE_REQUEST_LSB +: 3];
            ctrl.timestamp_capture_enable <= pwdata[`CAPTURE_ENABLE_BIT];
            ctrl.module_enable <= pwdata[`MODULE_ENABLE_BIT];
            ctrl.stop_in_idle <= pwdata[`STOP_IN_IDLE_BIT];
            ctrl.payload_compare_count <= pwdata[`COMPARE_COUNT_LSB +: 5];
         end
         if (wr_en && pwdata[`ABORT_ALL_BIT]) begin
            ctrl.abort_all_transmit <= 1'b1;
         end else if (abort_done) begin
            ctrl.abort_all_transmit <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         tx_abort <= '0;
      end else begin
         tx_abort <= ctrl.abort_all_transmit ? tx_pending : '0;
      end
   end

   // ****************************************
   // Mode sequencer
   // ****************************************
   logic request_legal;
   assign request_legal = ctrl.mode_request != 3'b101 && ctrl.mode_request != 3'b110;

   // A new mode takes effect only between frames so no frame is cut short.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         mode_current <= MODE_CONFIG;
      end else if (!bus_active && request_legal && ctrl.module_enable) begin
         mode_current <= mode_type'(ctrl.mode_request);
      end
   end

   // Module stays on until the frame in progress completes after a disable.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         module_on <= 1'b0;
      end else if (ctrl.module_enable) begin
         module_on <= 1'b1;
      end else if (!bus_active) begin
         module_on <= 1'b0;
      end
   end

   assign busy = module_on && (bus_active || !ctrl.module_enable);
   assign stop_in_idle = ctrl.stop_in_idle;
   assign payload_compare_count = ctrl.payload_compare_count;

   // ****************************************
   // Receive time stamp
   // ****************************************
   timestamp_timer #(
      .WIDTH(TIMER_WIDTH)
   ) u_timer (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .run(ctrl.timestamp_capture_enable),
      .tick(timer_tick),
      .count(timer_count)
   );

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rx_stamp <= '0;
      end else begin
         rx_stamp.rx_valid <= rx_event.rx_valid && ctrl.timestamp_capture_enable;
         if (rx_event.rx_valid && ctrl.timestamp_capture_enable) begin
            rx_stamp.rx_timestamp <= timer_count;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence s_abort_set;
      wr_en && pwdata[`ABORT_ALL_BIT];
   endsequence

   sequence s_disable_busy;
      module_on && !ctrl.module_enable && bus_active;
   endsequence

   sequence s_mode_ready;
      !bus_active && request_legal && ctrl.module_enable;
   endsequence

   // The abort mask follows the pending set one cycle late, so it lands two edges after the write.
   a_abort_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_abort_set |=> 1'b1 ##1 (tx_abort == $past(tx_pending)))
      else $error("abort not driven to pending buffers");
   a_abort_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !ctrl.abort_all_transmit |=> tx_abort == '0)
      else $error("abort driven without request");
   a_abort_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (abort_done && !(wr_en && pwdata[`ABORT_ALL_BIT])) |=> !ctrl.abort_all_transmit)
      else $error("abort bit did not self clear");
   a_abort_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (ctrl.abort_all_transmit && tx_pending != '0) |=> ctrl.abort_all_transmit)
      else $error("abort cleared early");
   a_mode_legal: assert property (@(posedge sys_clk) disable iff (sys_rst)
      mode_current != 3'b101 && mode_current != 3'b110)
      else $error("reserved mode reached");
   a_mode_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !request_legal |=> $stable(mode_current))
      else $error("reserved request changed the mode");
   a_mode_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (psel && !penable && !pwrite && rd_ctrl) |=>
         prdata[`MODE_STATUS_LSB +: 3] == $past(mode_current))
      else $error("mode status readback wrong");
   a_stamp_capture: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (rx_event.rx_valid && ctrl.timestamp_capture_enable) |=>
         rx_stamp.rx_valid && rx_stamp.rx_timestamp == $past(timer_count))
      else $error("timestamp not captured");
   a_stamp_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !rx_event.rx_valid |=> !rx_stamp.rx_valid)
      else $error("stamp without a received frame");
   a_timer_halt: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !ctrl.timestamp_capture_enable |=> $stable(timer_count) && !rx_stamp.rx_valid)
      else $error("timer ran with capture off");
   a_on_enable: assert property (@(posedge sys_clk) disable iff (sys_rst)
      ctrl.module_enable |=> module_on)
      else $error("module not on while enabled");
   a_off_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (!ctrl.module_enable && !bus_active) |=> !module_on && !busy)
      else $error("module stayed on after disable");
   a_busy_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_disable_busy |-> busy ##1 module_on)
      else $error("busy dropped during transaction");
   a_unused_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (psel && penable && !pwrite && rd_ctrl) |->
         (prdata & ~`CONTROL_WRITE_MASK & ~32'h00E00800) == '0)
      else $error("unimplemented bits read nonzero");
   // Checked without the reset guard, since it looks at the state that reset leaves behind.
   a_reset_config: assert property (@(posedge sys_clk)
      $past(sys_rst) |-> mode_current == MODE_CONFIG && !module_on && tx_abort == '0)
      else $error("reset state not configuration");
   a_mode_apply: assert property (@(posedge sys_clk) disable iff (sys_rst)
      s_mode_ready |=> mode_current == $past(ctrl.mode_request))
      else $error("requested mode not applied");
   a_mode_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst)
      bus_active |=> $stable(mode_current))
      else $error("mode changed during bus activity");

endmodule // can_mode_control

// ---- verif/can_bus_model.sv ----
// Behavioural model of the CAN bus side: frames, pending transmissions and timer ticks.
`timescale 1ns/1ps
module can_bus_model
   import can_mode_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic frame_go,
   input wire logic [7:0] frame_len,
   input wire logic load_go,
   input wire logic [31:0] load_val,
   input wire logic [31:0] tx_abort,
   output logic bus_active,
   output logic [31:0] tx_pending,
   output capture_type rx_event,
   output logic timer_tick
);
   import can_mode_pkg::*;
   logic [7:0] left;
   logic [1:0] div;
   assign bus_active = (left != 8'h00);
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         left <= 8'h00;
         div <= 2'h0;
         timer_tick <= 1'b0;
         rx_event <= '0;
         tx_pending <= 32'h0;
      end else begin
         div <= div + 2'h1;
         timer_tick <= (div == 2'h3);
         // The frame's stamp field is ignored by the block, so it is kept changing.
         rx_event <= {left == 8'h01, ~rx_event.rx_timestamp};
         if (frame_go) begin
            left <= frame_len;
         end else if (left != 8'h00) begin
            left <= left - 8'h01;
         end
         // A buffer abandons its frame one cycle after being told to.
         if (load_go) begin
            tx_pending <= load_val;
         end else begin
            tx_pending <= tx_pending & ~tx_abort;
         end
      end
   end
endmodule // can_bus_model

// ---- verif/tb_can_mode_control.sv ----
// Self-checking testbench of the CAN mode control block.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_can_mode_control;
   import can_mode_pkg::*;
   logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, tx_pending, tx_abort, load_val = 32'h0;
   logic bus_active, timer_tick, module_on, stop_in_idle, frame_go = 0, load_go = 0, e;
   logic [7:0] frame_len = 8'h00;
   logic [4:0] payload_compare_count;
   logic [31:0] r;
   capture_type rx_event, rx_stamp;
   mode_type mode_current;
   int bad_count = 0, tests_run = 0;
   always #4 sys_clk = ~sys_clk;
   can_mode_control uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_active(bus_active), .tx_pending(tx_pending),
      .tx_abort(tx_abort), .timer_tick(timer_tick), .rx_event(rx_event), .rx_stamp(rx_stamp),
      .mode_current(mode_current), .module_on(module_on), .stop_in_idle(stop_in_idle),
      .payload_compare_count(payload_compare_count));
   can_bus_model bus (.sys_clk(sys_clk), .sys_rst(sys_rst), .frame_go(frame_go),
      .frame_len(frame_len), .load_go(load_go), .load_val(load_val), .tx_abort(tx_abort),
      .bus_active(bus_active), .tx_pending(tx_pending), .rx_event(rx_event),
      .timer_tick(timer_tick));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin bad_count++; end_sim; end
      r = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   function automatic logic [31:0] ctl(logic en, logic [2:0] m);
      return {5'h00, m, 8'h00, en, 15'h0000};
   endfunction
   task automatic wait_mode(input mode_type m);
      int n;
      for (n = 0; n < 60 && mode_current !== m; n++) @(posedge sys_clk);
      `CHK(mode_current, m)
   endtask
   task automatic frame(input logic [7:0] len);
      frame_go <= 1'b1; frame_len <= len;
      @(posedge sys_clk);
      frame_go <= 1'b0;
   endtask
   task automatic stamp(output logic got, output logic [15:0] ts);
      int n;
      got = 0;
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge sys_clk);
         if (rx_stamp.rx_valid === 1'b1) begin got = 1; ts = rx_stamp.rx_timestamp; end
      end
   endtask
   task automatic t_reset;
      apb(0, 12'h000, 0);
      `CHK(r, 32'h04800000)
      `CHK(mode_current, MODE_CONFIG)
      `CHK({e, stop_in_idle, payload_compare_count}, 7'h00)
   endtask
   task automatic t_fields;
      apb(1, 12'h000, 32'hFFFFFFFF);
      repeat (3) @(posedge sys_clk);
      apb(0, 12'h000, 0);
      `CHK(r, 32'h07F0A01F)
      `CHK({stop_in_idle, payload_compare_count}, 6'h3F)
      apb(0, 12'h008, 0);
      `CHK({e, r}, 33'h100000000)
   endtask
   task automatic t_modes;
      mode_type m [6] = '{MODE_NORMAL, MODE_DISABLE, MODE_LOOPBACK, MODE_LISTEN_ONLY,
         MODE_LISTEN_ALL, MODE_CONFIG};
      foreach (m[i]) begin
         apb(1, 12'h000, ctl(1, m[i]));
         wait_mode(m[i]);
         apb(0, 12'h000, 0);
         `CHK(r[23:21], m[i])
      end
      // Reserved codes are written here only to see that they are never applied.
      apb(1, 12'h000, ctl(1, 3'h5));
      apb(1, 12'h000, ctl(1, 3'h6));
      repeat (3) @(posedge sys_clk);
      `CHK(mode_current, MODE_CONFIG)
   endtask
   task automatic t_busy_mode;
      frame(8'h1E);
      apb(1, 12'h000, ctl(1, MODE_LOOPBACK));
      `CHK(mode_current, MODE_CONFIG)
      wait_mode(MODE_LOOPBACK);
      frame(8'h1E);
      apb(1, 12'h000, ctl(0, MODE_LOOPBACK));
      apb(0, 12'h000, 0);
      `CHK({r[11], module_on}, 2'h3)
      for (int n = 0; n < 20 && r[11] !== 1'b0; n++) apb(0, 12'h000, 0);
      `CHK({r[11], module_on}, 2'h0)
   endtask
   task automatic t_abort;
      logic got;
      logic [15:0] a, b;
      apb(1, 12'h000, ctl(1, MODE_NORMAL));
      load_go <= 1'b1; load_val <= 32'h000000A5;
      @(posedge sys_clk);
      load_go <= 1'b0;
      apb(1, 12'h000, ctl(1, MODE_NORMAL) | 32'h08000000);
      for (int n = 0; n < 10 && tx_abort !== 32'hA5; n++) @(posedge sys_clk);
      `CHK(tx_abort, 32'h000000A5)
      apb(0, 12'h000, 0);
      `CHK(r[27], 1'b1)
      for (int n = 0; n < 20 && r[27] !== 1'b0; n++) apb(0, 12'h000, 0);
      `CHK({r[27], tx_pending}, 33'h0)
      frame(8'h10);
      stamp(got, a);
      `CHK(got, 1'b0)
      apb(1, 12'h000, ctl(1, MODE_NORMAL) | 32'h00100000);
      frame(8'h10);
      stamp(got, a);
      `CHK(got, 1'b1)
      frame(8'h10);
      stamp(got, b);
      `CHK(a != b, 1'b1)
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset;
      t_fields;
      t_modes;
      t_busy_mode;
      t_abort;
      end_sim;
   end
endmodule // tb_can_mode_control
